// ===== hdl/mspmc_pkg.sv
// Package for the motion sensor power mode controller: register map, fields, timing.
package mspmc_pkg;

  // Register byte addresses on the Wishbone bus
  localparam logic [7:0] ADDR_CLOCK_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_POWER_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_RATE_DIV    = 8'h08;
  localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;

  // Clock control fields
  localparam int CLK_SLEEP_BIT = 6;
  localparam int CLK_SEL_LSB   = 0;
  localparam logic [2:0] CLK_SEL_AUTO = 3'h1;

  // Power control fields
  localparam int PWR_GYRO_CYCLE_BIT = 7;
  localparam int PWR_GYRO_STBY_BIT  = 6;
  localparam int PWR_ACCEL_LSB      = 3;
  localparam int PWR_GYRO_LSB       = 0;

  // FIFO control fields
  localparam int FIFO_EN_BIT       = 0;
  localparam int FIFO_TEMP_DIS_BIT = 1;

  // Reset values
  localparam logic [7:0] CLOCK_CTRL_RST = 8'h41;
  localparam logic [7:0] POWER_CTRL_RST = 8'h00;
  localparam logic [7:0] RATE_DIV_RST   = 8'h00;
  localparam logic [7:0] FIFO_CTRL_RST  = 8'h00;

  // Timing
  localparam int CLK_MHZ           = 200;
  localparam int FIRST_SAMPLE_US   = 1000;
  localparam int OSC_SWITCH_US     = 20;
  localparam int BASE_PERIOD_NS    = 1000;
  localparam int FIRST_SAMPLE_CYC  = FIRST_SAMPLE_US * CLK_MHZ;
  localparam int OSC_SWITCH_CYC    = OSC_SWITCH_US * CLK_MHZ;
  localparam int BASE_PERIOD_CYC   = (BASE_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int CNT_W             = 18;

  typedef enum logic [1:0] {
    MSPMC_CLK_OFF  = 2'b00,
    MSPMC_CLK_OSC  = 2'b01,
    MSPMC_CLK_GYRO = 2'b10
  } mspmc_clk_src_t;

  typedef enum logic [1:0] {
    MSPMC_G_OFF   = 2'b00,
    MSPMC_G_LN    = 2'b01,
    MSPMC_G_LP    = 2'b10,
    MSPMC_G_STBY  = 2'b11
  } mspmc_gyro_mode_t;

  // Wishbone request and answer
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mspmc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } mspmc_wb_rsp_t;

  // Power outputs to the sensor front ends
  typedef struct packed {
    logic [2:0]     gyro_axis_on;
    logic [2:0]     accel_axis_on;
    logic           gyro_low_power;
    logic           temp_on;
    mspmc_clk_src_t clk_src;
  } mspmc_pwr_t;

endpackage : mspmc_pkg

// ===== hdl/mspmc_ctrl.sv
// Power mode and master clock controller with a Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - FIFO takes temperature unless capture disabled
// - Accel-only wake delays first sample 1 ms
// - New divider applies within one old sample; one written on the tick that loads an earlier pending one is not applied
// - Low-power to low-noise flags unsettled samples
// - Gyro cycle to standby, accel off: temp off
// - Gyro enters low power within one period
// - Cycle preset: first gyro sample low-noise
// - Auto clock: gyro clock when gyro on
// - Gyro off: switch to oscillator, 20 us
// - Sleep only from the sleep bit
// - All axes off keeps master clock running
// - FIFO usable in every mode except sleep and all axes off, where no sample pushes
module mspmc_ctrl
  import mspmc_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire mspmc_pkg::mspmc_wb_req_t wb_req,
  output var  mspmc_pkg::mspmc_wb_rsp_t wb_rsp,
  input  wire logic                    sample_tick,
  output var  mspmc_pkg::mspmc_pwr_t    pwr,
  output logic                         sample_valid,
  output logic                         sample_unsettled,
  output logic                         fifo_push_temp,
  output logic                         fifo_enabled
);
  import mspmc_pkg::*;

  typedef struct packed {
    logic [7:0]       clock_ctrl;
    logic [7:0]       power_ctrl;
    logic [7:0]       rate_div;
    logic [7:0]       fifo_ctrl;
    logic [7:0]       active_div;
    logic             div_pending;
    logic [7:0]       div_cnt;
    mspmc_gyro_mode_t gmode;
    logic             temp_on;
    mspmc_clk_src_t   clk_src;
    logic [CNT_W-1:0] osc_cnt;
    logic             osc_busy;
    logic [CNT_W-1:0] wake_cnt;
    logic             wake_wait;
    logic             lp_to_ln;
    logic             first_ln;
    logic             ack;
    logic [31:0]      rdata;
    logic             valid;
    logic             unsettled;
    logic             push_temp;
  } mspmc_state_t;

  mspmc_state_t s_q;
  mspmc_state_t s_d;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] wd, input logic [3:0] sel);
    merge_byte = sel[0] ? wd[7:0] : old_v;
  endfunction : merge_byte

  logic       wr;
  logic       rd_req;
  logic       sleep_bit;
  logic [2:0] gyro_dis;
  logic [2:0] accel_dis;
  logic       gyro_on_cfg;
  logic       accel_on_cfg;
  logic       out_tick;
  logic       gyro_start;
  logic       cycle_clear_wr;

  assign wr           = wb_req.cyc && wb_req.stb && wb_req.we && !s_q.ack;
  assign rd_req       = wb_req.cyc && wb_req.stb && !wb_req.we && !s_q.ack;
  assign sleep_bit    = s_q.clock_ctrl[CLK_SLEEP_BIT];
  assign gyro_dis     = s_q.power_ctrl[PWR_GYRO_LSB +: 3];
  assign accel_dis    = s_q.power_ctrl[PWR_ACCEL_LSB +: 3];
  assign gyro_on_cfg  = (gyro_dis != 3'h0 ? (gyro_dis != 3'h7) : 1'b1) && !sleep_bit;
  assign accel_on_cfg = (accel_dis != 3'h7) && !sleep_bit;
  // Output data rate tick after the sample rate divider
  assign out_tick     = sample_tick && (s_q.div_cnt == 8'h00);
  // Kept as events so that a sample in the same cycle cannot swallow a new start or cycle clear
  assign gyro_start     = (s_q.gmode == MSPMC_G_OFF) && gyro_on_cfg;
  assign cycle_clear_wr = wr && (wb_req.adr == ADDR_POWER_CTRL) && wb_req.sel[0]
                          && s_q.power_ctrl[PWR_GYRO_CYCLE_BIT] && !wb_req.dat[PWR_GYRO_CYCLE_BIT];

  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.valid = 1'b0;
    s_d.unsettled = 1'b0;
    s_d.push_temp = 1'b0;

    if (wr)
    begin
      if (wb_req.adr == ADDR_CLOCK_CTRL)
      begin
        s_d.clock_ctrl = merge_byte(s_q.clock_ctrl, wb_req.dat, wb_req.sel);
        // arm first sample delay on wake
        if (sleep_bit && !wb_req.dat[CLK_SLEEP_BIT] && wb_req.sel[0] && (gyro_dis == 3'h7))
        begin
          s_d.wake_wait = 1'b1;
          s_d.wake_cnt  = CNT_W'(FIRST_SAMPLE_CYC);
        end
      end
      else if (wb_req.adr == ADDR_POWER_CTRL)
      begin
        s_d.power_ctrl = merge_byte(s_q.power_ctrl, wb_req.dat, wb_req.sel);
        // cycle cleared means low-power to low-noise
        if (cycle_clear_wr)
          s_d.lp_to_ln = 1'b1;
      end
      else if (wb_req.adr == ADDR_RATE_DIV)
      begin
        s_d.rate_div = merge_byte(s_q.rate_div, wb_req.dat, wb_req.sel);
        s_d.div_pending = wb_req.sel[0];
      end
      else if (wb_req.adr == ADDR_FIFO_CTRL)
        s_d.fifo_ctrl = merge_byte(s_q.fifo_ctrl, wb_req.dat, wb_req.sel);
    end

    if (wr || rd_req)
      s_d.ack = 1'b1;
    s_d.rdata = 32'h0000_0000;
    if (rd_req)
    begin
      if (wb_req.adr == ADDR_CLOCK_CTRL)
        s_d.rdata[7:0] = s_q.clock_ctrl;
      else if (wb_req.adr == ADDR_POWER_CTRL)
        s_d.rdata[7:0] = s_q.power_ctrl;
      else if (wb_req.adr == ADDR_RATE_DIV)
        s_d.rdata[7:0] = s_q.rate_div;
      else if (wb_req.adr == ADDR_FIFO_CTRL)
        s_d.rdata[7:0] = s_q.fifo_ctrl;
      else if (wb_req.adr == ADDR_STATUS)
        s_d.rdata[7:0] = {s_q.osc_busy, s_q.wake_wait, s_q.temp_on, s_q.gmode, s_q.clk_src, 1'b0};
    end

    // divider reload on an old-rate sample
    if (sample_tick)
    begin
      if (s_q.div_cnt == 8'h00)
      begin
        s_d.div_cnt = s_q.div_pending ? s_q.rate_div : s_q.active_div;
        if (s_q.div_pending)
        begin
          s_d.active_div  = s_q.rate_div;
          s_d.div_pending = 1'b0;
        end
      end
      else
        s_d.div_cnt = s_q.div_cnt - 8'h01;
    end

    // Gyroscope mode sequencing
    case (s_q.gmode)
      MSPMC_G_OFF:
      begin
        if (gyro_on_cfg)
        begin
          s_d.gmode    = MSPMC_G_LN;
          s_d.first_ln = 1'b1;
        end
      end
      MSPMC_G_LN:
      begin
        if (!gyro_on_cfg)
          s_d.gmode = MSPMC_G_OFF;
        else if (s_q.power_ctrl[PWR_GYRO_STBY_BIT])
          s_d.gmode = MSPMC_G_STBY;
        // low power entered at the next period
        else if (s_q.power_ctrl[PWR_GYRO_CYCLE_BIT] && out_tick && !s_q.first_ln)
          s_d.gmode = MSPMC_G_LP;
      end
      MSPMC_G_LP:
      begin
        if (!gyro_on_cfg)
          s_d.gmode = MSPMC_G_OFF;
        else if (s_q.power_ctrl[PWR_GYRO_STBY_BIT])
        begin
          s_d.gmode = MSPMC_G_STBY;
          if (!accel_on_cfg)
            s_d.temp_on = 1'b0;
        end
        else if (!s_q.power_ctrl[PWR_GYRO_CYCLE_BIT])
          s_d.gmode = MSPMC_G_LN;
      end
      MSPMC_G_STBY:
      begin
        // leaving standby needs the bit cleared first
        if (!s_q.power_ctrl[PWR_GYRO_STBY_BIT])
          s_d.gmode = gyro_on_cfg ? MSPMC_G_LN : MSPMC_G_OFF;
      end
      default:
        s_d.gmode = MSPMC_G_OFF;
    endcase
    if (s_q.gmode != MSPMC_G_STBY && s_d.gmode != MSPMC_G_STBY)
      s_d.temp_on = (gyro_on_cfg || accel_on_cfg);
    else if (s_q.gmode == MSPMC_G_STBY && accel_on_cfg)
      s_d.temp_on = 1'b1;

    // sleep only by the sleep bit
    if (sleep_bit)
    begin
      s_d.clk_src  = MSPMC_CLK_OFF;
      s_d.osc_busy = 1'b0;
      s_d.gmode    = MSPMC_G_OFF;
      s_d.temp_on  = 1'b0;
    end
    else if (gyro_on_cfg && s_q.clock_ctrl[CLK_SEL_LSB +: 3] == CLK_SEL_AUTO)
    begin
      s_d.clk_src  = MSPMC_CLK_GYRO;
      s_d.osc_busy = 1'b0;
    end
    // move to oscillator taking 20 us
    else if (s_q.clk_src == MSPMC_CLK_GYRO && !s_q.osc_busy)
    begin
      s_d.osc_busy = 1'b1;
      s_d.osc_cnt  = CNT_W'(OSC_SWITCH_CYC);
    end
    else if (s_q.osc_busy)
    begin
      if (s_q.osc_cnt == '0)
      begin
        s_d.osc_busy = 1'b0;
        s_d.clk_src  = MSPMC_CLK_OSC;
      end
      else
        s_d.osc_cnt = s_q.osc_cnt - CNT_W'(1);
    end
    // master clock keeps running with axes off
    else
      s_d.clk_src = MSPMC_CLK_OSC;

    if (s_q.wake_wait)
    begin
      if (s_q.wake_cnt == '0)
        s_d.wake_wait = 1'b0;
      else
        s_d.wake_cnt = s_q.wake_cnt - CNT_W'(1);
    end

    // Sample production
    if (out_tick && !s_q.wake_wait && (gyro_on_cfg || accel_on_cfg))
    begin
      s_d.valid = 1'b1;
      if (s_q.first_ln || s_q.lp_to_ln)
      begin
        s_d.unsettled = 1'b1;
        // Set wins over clear when both land in one cycle
        s_d.first_ln  = gyro_start;
        s_d.lp_to_ln  = cycle_clear_wr;
      end
      // no mode gating of the FIFO
      s_d.push_temp = s_q.fifo_ctrl[FIFO_EN_BIT] && !s_q.fifo_ctrl[FIFO_TEMP_DIS_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q            <= '0;
      // Sleep bit set out of reset: nothing powers up until software wakes the part
      s_q.clock_ctrl <= CLOCK_CTRL_RST;
      s_q.power_ctrl <= POWER_CTRL_RST;
      s_q.rate_div   <= RATE_DIV_RST;
      s_q.fifo_ctrl  <= FIFO_CTRL_RST;
      s_q.gmode      <= MSPMC_G_OFF;
      s_q.clk_src    <= MSPMC_CLK_OFF;
    end
    else
      s_q <= s_d;
  end

  assign wb_rsp.ack         = s_q.ack;
  assign wb_rsp.dat         = s_q.rdata;
  assign pwr.gyro_axis_on   = (s_q.gmode == MSPMC_G_LN || s_q.gmode == MSPMC_G_LP) ? ~gyro_dis : 3'h0;
  assign pwr.accel_axis_on  = sleep_bit ? 3'h0 : ~accel_dis;
  assign pwr.gyro_low_power = (s_q.gmode == MSPMC_G_LP);
  assign pwr.temp_on        = s_q.temp_on;
  assign pwr.clk_src        = s_q.clk_src;
  assign sample_valid       = s_q.valid;
  assign sample_unsettled   = s_q.unsettled;
  assign fifo_push_temp     = s_q.push_temp;
  assign fifo_enabled       = s_q.fifo_ctrl[FIFO_EN_BIT];

  chk_sleep_clock_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    sleep_bit |=> s_q.clk_src == MSPMC_CLK_OFF) else $error("clock not stopped in sleep");
  chk_idle_clock_runs: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!sleep_bit && !gyro_on_cfg && !s_q.osc_busy && s_q.clk_src != MSPMC_CLK_GYRO) |=> s_q.clk_src == MSPMC_CLK_OSC)
    else $error("master clock stopped without sleep");
  chk_auto_gyro_clock: assert property (@(posedge core_clk) disable iff (!rst_b)
    (gyro_on_cfg && s_q.clock_ctrl[CLK_SEL_LSB +: 3] == CLK_SEL_AUTO) |=> s_q.clk_src == MSPMC_CLK_GYRO)
    else $error("gyro clock not selected");
  sequence osc_start_s;
    $rose(s_q.osc_busy);
  endsequence
  chk_osc_switch_time: assert property (@(posedge core_clk) disable iff (!rst_b)
    osc_start_s ##0 (!sleep_bit && !gyro_on_cfg) [*8] |-> s_q.clk_src == MSPMC_CLK_GYRO)
    else $error("oscillator switch too early");
  chk_temp_push: assert property (@(posedge core_clk) disable iff (!rst_b)
    fifo_push_temp |-> $past(s_q.fifo_ctrl[FIFO_EN_BIT]) && $past(!s_q.fifo_ctrl[FIFO_TEMP_DIS_BIT]) && sample_valid)
    else $error("temperature push not allowed");
  chk_temp_off_stby: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.gmode == MSPMC_G_LP && s_q.power_ctrl[PWR_GYRO_STBY_BIT] && gyro_on_cfg && !accel_on_cfg) |=> !s_q.temp_on)
    else $error("temp sensor left on");
  chk_cycle_entry: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.gmode == MSPMC_G_LN && !s_q.first_ln && s_q.power_ctrl[PWR_GYRO_CYCLE_BIT]
      && !s_q.power_ctrl[PWR_GYRO_STBY_BIT] && gyro_on_cfg && out_tick)
    |=> s_q.gmode == MSPMC_G_LP) else $error("low power not entered");
  chk_first_lownoise: assert property (@(posedge core_clk) disable iff (!rst_b)
    (s_q.gmode == MSPMC_G_OFF && gyro_on_cfg) |=> s_q.gmode == MSPMC_G_LN && s_q.first_ln)
    else $error("first gyro sample not low-noise");
  chk_wake_delay: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_q.wake_wait |=> !sample_valid) else $error("sample during wake delay");

endmodule : mspmc_ctrl

`default_nettype wire

// ===== sim/mspmc_host_model.sv
// Host model: classic Wishbone master that programs the controller.
`timescale 1ns/1ps
`default_nettype none
module mspmc_host_model (
  input  wire logic                     core_clk,
  input  wire mspmc_pkg::mspmc_wb_rsp_t wb_rsp,
  output var  mspmc_pkg::mspmc_wb_req_t wb_req
);
  import mspmc_pkg::*;
  logic asleep;
  initial
  begin
    wb_req = '0;
    asleep = 1'b1;
  end
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h00_0000, wd}};
    // No local limit: only the bench watchdog ends a wait that never sees ack
    do
    begin
      @(posedge core_clk);
    end
    while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [7:0] d;
    if (adr == ADDR_CLOCK_CTRL)
      asleep = wd[CLK_SLEEP_BIT];
    xfer(1'b1, adr, wd, d);
  endtask : wr
  task automatic rd(input logic [7:0] adr, output logic [7:0] d);
    d = 8'h00;
    // places above the status address never read while asleep
    if (!(asleep && adr > ADDR_STATUS))
      xfer(1'b0, adr, 8'h00, d);
  endtask : rd
endmodule : mspmc_host_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the power mode controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mspmc_pkg::*;
  logic          core_clk;
  logic          rst_b;
  logic          sample_tick;
  mspmc_wb_req_t wb_req;
  mspmc_wb_rsp_t wb_rsp;
  mspmc_pwr_t    pwr;
  logic          sample_valid;
  logic          sample_unsettled;
  logic          fifo_push_temp;
  logic          fifo_enabled;
  int            n_mismatch;
  int            total_checks;
  int            n;
  logic [7:0]    rdat;
  logic [2:0]    seen;
  mspmc_ctrl dut_u (.core_clk(core_clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .sample_tick(sample_tick), .pwr(pwr), .sample_valid(sample_valid),
    .sample_unsettled(sample_unsettled), .fifo_push_temp(fifo_push_temp), .fifo_enabled(fifo_enabled));
  mspmc_host_model host_u (.core_clk(core_clk), .wb_rsp(wb_rsp), .wb_req(wb_req));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk
  // Seen holds valid, unsettled and temperature push one cycle after the tick
  task automatic tick();
    @(posedge core_clk);
    sample_tick <= 1'b1;
    @(posedge core_clk);
    sample_tick <= 1'b0;
    #1;
    seen = {sample_valid, sample_unsettled, fifo_push_temp};
  endtask : tick
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic wait_src(input mspmc_clk_src_t s);
    n = 0;
    while (pwr.clk_src !== s && n < 8000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask : wait_src
  task automatic reset_values();
    host_u.rd(ADDR_CLOCK_CTRL, rdat);
    chk(rdat, CLOCK_CTRL_RST, "clock ctrl reset");
    host_u.rd(ADDR_POWER_CTRL, rdat);
    chk(rdat, POWER_CTRL_RST, "power ctrl reset");
    chk(8'(pwr.clk_src), 8'(MSPMC_CLK_OFF), "clock off asleep");
  endtask : reset_values
  task automatic wake_gyro();
    host_u.wr(ADDR_FIFO_CTRL, 8'h01);
    host_u.wr(ADDR_POWER_CTRL, 8'h38);
    host_u.wr(ADDR_CLOCK_CTRL, 8'h01);
    wait_src(MSPMC_CLK_GYRO);
    chk(8'(pwr.clk_src), 8'(MSPMC_CLK_GYRO), "gyro clock");
    tick();
    chk(8'(seen), 8'h07, "first gyro sample");
    tick();
    chk(8'(seen), 8'h05, "settled sample");
    host_u.wr(ADDR_FIFO_CTRL, 8'h03);
    tick();
    chk(8'(seen), 8'h04, "temp capture off");
    chk(8'(fifo_enabled), 8'h01, "fifo enable level");
    host_u.rd(8'h20, rdat);
    chk(rdat, 8'h00, "unmapped read");
  endtask : wake_gyro
  task automatic gyro_off_clock();
    host_u.wr(ADDR_POWER_CTRL, 8'h3F);
    wait_src(MSPMC_CLK_OSC);
    // Counted from the ack edge, so a few cycles of slack either way
    chk(8'(n > OSC_SWITCH_CYC - 8 && n < OSC_SWITCH_CYC + 8), 8'h01, "osc switch time");
    chk(8'({pwr.gyro_axis_on, pwr.accel_axis_on}), 8'h00, "axes off");
    tick();
    chk(8'(seen[2]), 8'h00, "no sample with axes off");
    chk(8'(pwr.clk_src), 8'(MSPMC_CLK_OSC), "clock kept running");
  endtask : gyro_off_clock
  task automatic divider_change();
    host_u.wr(ADDR_POWER_CTRL, 8'h38);
    tick();
    host_u.wr(ADDR_RATE_DIV, 8'h01);
    tick();
    chk(8'(seen[2]), 8'h01, "old rate sample");
    n = 0;
    repeat (4)
    begin
      tick();
      n += int'(seen[2]);
    end
    chk(8'(n), 8'h02, "new rate");
    host_u.wr(ADDR_RATE_DIV, 8'h00);
    repeat (2) tick();
  endtask : divider_change
  task automatic gyro_cycle();
    host_u.wr(ADDR_POWER_CTRL, 8'h3F);
    wait_src(MSPMC_CLK_OSC);
    host_u.wr(ADDR_POWER_CTRL, 8'hBF);
    host_u.wr(ADDR_POWER_CTRL, 8'hB8);
    tick();
    chk(8'(seen[2:1]), 8'h03, "cycle preset first sample");
    tick();
    settle();
    chk(8'(pwr.gyro_low_power), 8'h01, "low power in one period");
    // cycle cleared while in low power
    host_u.wr(ADDR_POWER_CTRL, 8'h38);
    tick();
    chk(8'(seen[2:1]), 8'h03, "unsettled after low power");
    host_u.wr(ADDR_POWER_CTRL, 8'hB8);
    tick();
    chk(8'(pwr.gyro_low_power), 8'h01, "low power again");
  endtask : gyro_cycle
  task automatic standby_temp();
    host_u.wr(ADDR_POWER_CTRL, 8'hF8);
    settle();
    chk(8'({pwr.gyro_axis_on, pwr.temp_on}), 8'h00, "temp off from cycle");
    host_u.wr(ADDR_POWER_CTRL, 8'hB8);
    // cycle cleared an output period ahead
    host_u.wr(ADDR_POWER_CTRL, 8'h38);
    repeat (2) tick();
    // gyro axes on when standby is set
    host_u.wr(ADDR_POWER_CTRL, 8'h78);
    settle();
    chk(8'(pwr.temp_on), 8'h01, "temp kept in standby");
    host_u.wr(ADDR_POWER_CTRL, 8'h38);
  endtask : standby_temp
  task automatic sleep_entry();
    host_u.wr(ADDR_CLOCK_CTRL, 8'h41);
    settle();
    chk(8'(pwr.clk_src), 8'(MSPMC_CLK_OFF), "sleep bit sleeps");
    host_u.wr(ADDR_POWER_CTRL, 8'h07);
    host_u.wr(ADDR_CLOCK_CTRL, 8'h01);
    chk(8'(pwr.accel_axis_on), 8'h07, "accel on after wake");
    repeat (4) tick();
    chk(8'(seen[2]), 8'h00, "accel wake wait");
    host_u.rd(ADDR_STATUS, rdat);
    chk(8'(rdat[6]), 8'h01, "wake wait flag");
  endtask : sleep_entry
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    rst_b = 1'b0;
    sample_tick = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    reset_values();
    wake_gyro();
    gyro_off_clock();
    divider_change();
    gyro_cycle();
    standby_temp();
    sleep_entry();
    give_verdict();
  end
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
